// ==== src/ilpc_pkg.sv ====
// Behaviour
// - Ten 16-bit level registers, software reachable
// - Level fields in bits 10:8 and 2:0
// - All level fields reset to zero
// - First three registers map port, timekeeping, supply sources
// - Next three map display, PWM, timer sources
// - Registers map serial sources and converters
// - PWM1 register holds only low field
// - Highest programmed level pending request wins
// - Equal levels: smallest vector number wins
// - Losing requests stay pending, presented later
// - Higher newcomer displaces unaccepted request
// - Requests are level sensitive, re-raise
// - Cleared flag drops pending request
// - Core interface: strobe, level, vector
package ilpc_pkg;
  localparam int NUM_SRC = 20;
  localparam int NUM_REG = 10;
  localparam int LVL_W   = 3;
  localparam int VEC_W   = 5;
  localparam int ADDR_W  = 18;
  localparam int DATA_W  = 32;
  localparam int REG_W   = 16;
  localparam int LO_LSB  = 0;
  localparam int HI_LSB  = 8;
  // Register indices; byte address is four times the index
  localparam logic [15:0] REG_IDX [NUM_REG] = '{
    16'h4306, 16'h4308, 16'h430a, 16'h430c, 16'h430e,
    16'h4310, 16'h4312, 16'h4314, 16'h4316, 16'h4318};
  // Registers that hold a high field
  localparam logic [NUM_REG-1:0] REG_HAS_HIGH = 10'h2ff;
  localparam logic [LVL_W-1:0] LVL_RST = 3'h0;
  // Base of the source vector table, value is arbitrary
  localparam logic [VEC_W-1:0] VEC_BASE = 5'h04;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {OUT_IDLE, OUT_DRIVE, OUT_GAP} ilpc_out_e;
endpackage

// ==== src/ilpc_level_pair.sv ====
`timescale 1ns/1ps
`default_nettype none
module ilpc_level_pair
  import ilpc_pkg::*;
#(
  parameter bit HAS_HIGH = 1'b1
) (
  input  wire logic             sys_clk,  // System clock
  input  wire logic             srst,     // Synchronous reset
  input  wire logic             wrEn,     // Write this register
  input  wire logic [1:0]       wrStrb,   // Byte lanes
  input  wire logic [REG_W-1:0] wrData,   // Write word
  output logic      [LVL_W-1:0] loLevel,  // Low source level
  output logic      [LVL_W-1:0] hiLevel,  // High source level
  output logic      [REG_W-1:0] readWord  // Read view
);
  logic [LVL_W-1:0] lo_r;
  logic [LVL_W-1:0] lo_nxt;
  logic [LVL_W-1:0] hi_r;
  logic [LVL_W-1:0] hi_nxt;

  // Field updates by byte lane
  always_comb begin
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    if (wrEn && wrStrb[0]) begin
      lo_nxt = wrData[LO_LSB +: LVL_W];
    end
    if (HAS_HIGH && wrEn && wrStrb[1]) begin
      hi_nxt = wrData[HI_LSB +: LVL_W];
    end
  end

  // Level storage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lo_r <= LVL_RST;
      hi_r <= LVL_RST;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
    end
  end

  // Reserved bits read as zero
  assign loLevel  = lo_r;
  assign hiLevel  = hi_r;
  assign readWord = {5'h00, hi_r, 5'h00, lo_r};
endmodule
`default_nettype wire

// ==== src/ilpc_prio_pick.sv ====
`timescale 1ns/1ps
`default_nettype none
module ilpc_prio_pick
  import ilpc_pkg::*;
(
  input  wire logic [NUM_SRC-1:0]       req,       // Pending flags
  input  wire logic [NUM_SRC*LVL_W-1:0] levels,    // Levels, packed
  output logic                          pickValid, // A request wins
  output logic      [LVL_W-1:0]         pickLvl,   // Winning level
  output logic      [VEC_W-1:0]         pickVec    // Winning vector
);
  // Scan all sources, keep best level then smallest vector
  always_comb begin
    logic [LVL_W-1:0] lvl;
    logic [VEC_W-1:0] vec;
    pickValid = 1'b0;
    pickLvl   = LVL_RST;
    pickVec   = VEC_BASE;
    lvl       = LVL_RST;
    vec       = VEC_BASE;
    for (int i = 0; i < NUM_SRC; i++) begin
      lvl = levels[i*LVL_W +: LVL_W];
      vec = VEC_BASE + VEC_W'(i);
      if (req[i] && lvl != LVL_RST) begin
        if (!pickValid || lvl > pickLvl) begin
          pickValid = 1'b1;
          pickLvl   = lvl;
          pickVec   = vec;
        end else if (lvl == pickLvl && vec < pickVec) begin
          pickVec = vec;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/ilpc_top.sv ====
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ilpc_top
  import ilpc_pkg::*;
(
  input  wire logic               sys_clk,       // System clock
  input  wire logic               srst,          // Sync reset
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,  // Write address
  input  wire logic               s_axi_awvalid, // Write addr valid
  output logic                    s_axi_awready, // Write addr ready
  input  wire logic [DATA_W-1:0]  s_axi_wdata,   // Write data
  input  wire logic [3:0]         s_axi_wstrb,   // Write strobes
  input  wire logic               s_axi_wvalid,  // Write data valid
  output logic                    s_axi_wready,  // Write data ready
  output logic [1:0]              s_axi_bresp,   // Write response
  output logic                    s_axi_bvalid,  // Response valid
  input  wire logic               s_axi_bready,  // Response ready
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,  // Read address
  input  wire logic               s_axi_arvalid, // Read addr valid
  output logic                    s_axi_arready, // Read addr ready
  output logic [DATA_W-1:0]       s_axi_rdata,   // Read data
  output logic [1:0]              s_axi_rresp,   // Read response
  output logic                    s_axi_rvalid,  // Read data valid
  input  wire logic               s_axi_rready,  // Read data ready
  input  wire logic [NUM_SRC-1:0] srcReq,        // Source flags
  input  wire logic               coreAccept,    // Core takes request
  output logic                    irqReq,        // Request strobe
  output logic [LVL_W-1:0]        irqLevel,      // Request level
  output logic [VEC_W-1:0]        irqVector      // Request vector
);
  // Write channel state
  logic              awHeld_r;
  logic              awHeld_nxt;
  logic              wHeld_r;
  logic              wHeld_nxt;
  logic [15:0]       awIdx_r;
  logic [15:0]       awIdx_nxt;
  logic [REG_W-1:0]  wData_r;
  logic [REG_W-1:0]  wData_nxt;
  logic [1:0]        wStrb_r;
  logic [1:0]        wStrb_nxt;
  logic              bValid_r;
  logic              bValid_nxt;
  logic [1:0]        bResp_r;
  logic [1:0]        bResp_nxt;
  logic              awReady_r;
  logic              awReady_nxt;
  logic              wReady_r;
  logic              wReady_nxt;

  // Read channel state
  logic              arReady_r;
  logic              arReady_nxt;
  logic              rValid_r;
  logic              rValid_nxt;
  logic [DATA_W-1:0] rData_r;
  logic [DATA_W-1:0] rData_nxt;
  logic [1:0]        rResp_r;
  logic [1:0]        rResp_nxt;

  // Core request state
  ilpc_out_e         outState_r;
  ilpc_out_e         outState_nxt;
  logic              req_r;
  logic              req_nxt;
  logic [LVL_W-1:0]  lvl_r;
  logic [LVL_W-1:0]  lvl_nxt;
  logic [VEC_W-1:0]  vec_r;
  logic [VEC_W-1:0]  vec_nxt;

  // Register file wiring
  logic                     commit;
  logic [NUM_REG-1:0]       wrHit;
  logic                     wrMapped;
  logic [NUM_REG-1:0]       rdHit;
  logic                     rdMapped;
  logic [REG_W-1:0]         rdWord;
  logic [REG_W-1:0]         regWord [NUM_REG];
  logic [NUM_SRC*LVL_W-1:0] allLevels;
  logic                     pickValid;
  logic [LVL_W-1:0]         pickLvl;
  logic [VEC_W-1:0]         pickVec;

  // A write is done once address and data are both held and no write response is pending
  assign commit = awHeld_r && wHeld_r && !bValid_r;

  // Address decode, index compared with word address
  always_comb begin
    wrHit    = '0;
    rdHit    = '0;
    rdWord   = '0;
    for (int r = 0; r < NUM_REG; r++) begin
      wrHit[r] = (awIdx_r == REG_IDX[r]);
      rdHit[r] = (s_axi_araddr[ADDR_W-1:2] == REG_IDX[r]);
      if (rdHit[r]) begin
        rdWord = regWord[r];
      end
    end
    wrMapped = |wrHit;
    rdMapped = |rdHit;
  end

  // One register per pair of sources
  generate
    for (genvar g = 0; g < NUM_REG; g++) begin : gLvl
      ilpc_level_pair #(
        .HAS_HIGH (REG_HAS_HIGH[g])
      ) uPair (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .wrEn     (commit && wrHit[g]),
        .wrStrb   (wStrb_r),
        .wrData   (wData_r),
        .loLevel  (allLevels[(2*g)*LVL_W +: LVL_W]),
        .hiLevel  (allLevels[(2*g+1)*LVL_W +: LVL_W]),
        .readWord (regWord[g])
      );
    end
  endgenerate

  // Arbiter over live flags; cleared flags vanish at once
  ilpc_prio_pick uPick (
    .req       (srcReq),
    .levels    (allLevels),
    .pickValid (pickValid),
    .pickLvl   (pickLvl),
    .pickVec   (pickVec)
  );

  // Write address and data capture, response after both
  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt  = wHeld_r;
    awIdx_nxt  = awIdx_r;
    wData_nxt  = wData_r;
    wStrb_nxt  = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt  = bResp_r;
    if (s_axi_awvalid && awReady_r) begin
      awHeld_nxt = 1'b1;
      awIdx_nxt  = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && wReady_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata[REG_W-1:0];
      wStrb_nxt = s_axi_wstrb[1:0];
    end
    if (commit) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = wrMapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    awReady_nxt = !awHeld_nxt;
    wReady_nxt  = !wHeld_nxt;
  end

  // Write channel registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      awHeld_r  <= 1'b0;
      wHeld_r   <= 1'b0;
      awIdx_r   <= '0;
      wData_r   <= '0;
      wStrb_r   <= '0;
      bValid_r  <= 1'b0;
      bResp_r   <= RESP_OKAY;
      awReady_r <= 1'b0;
      wReady_r  <= 1'b0;
    end else begin
      awHeld_r  <= awHeld_nxt;
      wHeld_r   <= wHeld_nxt;
      awIdx_r   <= awIdx_nxt;
      wData_r   <= wData_nxt;
      wStrb_r   <= wStrb_nxt;
      bValid_r  <= bValid_nxt;
      bResp_r   <= bResp_nxt;
      awReady_r <= awReady_nxt;
      wReady_r  <= wReady_nxt;
    end
  end

  // Read answers one cycle after the address is taken
  always_comb begin
    arReady_nxt = arReady_r || !rValid_r;  // Ready again once idle
    rValid_nxt  = rValid_r;
    rData_nxt   = rData_r;
    rResp_nxt   = rResp_r;
    if (s_axi_arvalid && arReady_r) begin
      arReady_nxt = 1'b0;
      rValid_nxt  = 1'b1;
      rData_nxt   = {16'h0000, rdWord};
      rResp_nxt   = rdMapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (rValid_r && s_axi_rready) begin
      rValid_nxt  = 1'b0;
      arReady_nxt = 1'b1;
    end
  end

  // Read channel registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      arReady_r <= 1'b0;
      rValid_r  <= 1'b0;
      rData_r   <= '0;
      rResp_r   <= RESP_OKAY;
    end else begin
      arReady_r <= arReady_nxt;
      rValid_r  <= rValid_nxt;
      rData_r   <= rData_nxt;
      rResp_r   <= rResp_nxt;
    end
  end

  // Request presentation to the core
  always_comb begin
    outState_nxt = outState_r;
    req_nxt      = req_r;
    lvl_nxt      = lvl_r;
    vec_nxt      = vec_r;
    unique case (outState_r)
      OUT_IDLE: begin
        if (pickValid) begin
          outState_nxt = OUT_DRIVE;
          req_nxt      = 1'b1;
          lvl_nxt      = pickLvl;
          vec_nxt      = pickVec;
        end
      end
      OUT_DRIVE: begin
        if (coreAccept) begin
          outState_nxt = OUT_GAP;
          req_nxt      = 1'b0;
        end else if (!pickValid) begin
          outState_nxt = OUT_IDLE;
          req_nxt      = 1'b0;
        end else begin
          lvl_nxt = pickLvl;
          vec_nxt = pickVec;
        end
      end
      OUT_GAP: begin
        outState_nxt = OUT_IDLE;
        req_nxt      = 1'b0;
      end
    endcase
  end

  // Core request registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      outState_r <= OUT_IDLE;
      req_r      <= 1'b0;
      lvl_r      <= LVL_RST;
      vec_r      <= VEC_BASE;
    end else begin
      outState_r <= outState_nxt;
      req_r      <= req_nxt;
      lvl_r      <= lvl_nxt;
      vec_r      <= vec_nxt;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;
  assign irqReq        = req_r;
  assign irqLevel      = lvl_r;
  assign irqVector     = vec_r;

  // Checker helpers: a better pending source than the next output
  logic higherPend;
  logic tieLower;
  always_comb begin
    higherPend = 1'b0;
    tieLower   = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (srcReq[i] && allLevels[i*LVL_W +: LVL_W] > lvl_nxt) begin
        higherPend = 1'b1;
      end
      if (srcReq[i] && allLevels[i*LVL_W +: LVL_W] == lvl_nxt
          && VEC_BASE + VEC_W'(i) < vec_nxt) begin
        tieLower = 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_levels_reset: assert property (
    $past(srst) |-> allLevels == '0)
    else $error("level fields not zero after reset");

  chk_reserved_read: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:11] == '0 && s_axi_rdata[7:3] == '0)
    else $error("reserved read bits not zero");

  chk_pwm1_high: assert property (
    allLevels[17*LVL_W +: LVL_W] == LVL_RST)
    else $error("absent high field holds a level");

  chk_highest_wins: assert property (
    req_nxt |-> !higherPend)
    else $error("higher pending level not chosen");

  chk_tie_vector: assert property (
    req_nxt |-> !tieLower)
    else $error("equal level with smaller vector not chosen");

  chk_displace_new: assert property (
    irqReq && !coreAccept && pickValid && pickLvl > irqLevel
    |=> irqReq && irqLevel == $past(pickLvl) && irqVector == $past(pickVec))
    else $error("newer higher request did not displace");

  chk_drop_cleared: assert property (
    irqReq && !coreAccept && !pickValid |=> !irqReq)
    else $error("request kept after flag cleared");

  chk_reraise_level: assert property (
    irqReq && coreAccept |=> !irqReq ##1 !irqReq
    ##1 (irqReq == $past(pickValid)))
    else $error("accepted request not gapped or not re-raised");

  chk_write_next: assert property (
    commit && wrHit[0] && wStrb_r[0] |=> allLevels[2:0] == $past(wData_r[2:0]))
    else $error("level write not in effect next cycle");

  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule
`default_nettype wire

// ==== dv/ilpc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ilpc_core_model
  import ilpc_pkg::*;
(
  input  wire logic             sys_clk,     // System clock
  input  wire logic             srst,        // Sync reset
  input  wire logic             irqReq,      // Request strobe
  input  wire logic [LVL_W-1:0] irqLevel,    // Request level
  input  wire logic             acceptEn,    // Core interrupt enable
  input  wire logic [LVL_W-1:0] curLevel,    // Core current level
  input  wire logic [3:0]       acceptDelay, // Wait before taking
  output var  logic             coreAccept   // Take pulse
);
  logic [3:0] waitCnt_r;

  // Take an eligible request after the delay, one pulse per request
  always_ff @(posedge sys_clk) begin
    if (srst || coreAccept) begin
      waitCnt_r  <= 4'h0;
      coreAccept <= 1'b0;
    end else if (acceptEn && irqReq && irqLevel != 3'h0 &&
                 irqLevel > curLevel) begin
      if (waitCnt_r >= acceptDelay) begin
        coreAccept <= 1'b1;
      end else begin
        waitCnt_r <= waitCnt_r + 4'h1;
      end
    end else begin
      waitCnt_r <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ilpc_pkg::*;
;
  logic               sys_clk     = 1'b0;
  logic               srst        = 1'b1;
  logic [ADDR_W-1:0]  awAddr      = '0;
  logic [ADDR_W-1:0]  arAddr      = '0;
  logic [DATA_W-1:0]  wData       = '0;
  logic [3:0]         wStrb       = 4'h0;
  logic               awValid     = 1'b0;
  logic               wValid      = 1'b0;
  logic               bReady      = 1'b0;
  logic               arValid     = 1'b0;
  logic               rReady      = 1'b0;
  logic [NUM_SRC-1:0] srcReq      = '0;
  logic               acceptEn    = 1'b0;
  logic [LVL_W-1:0]   curLevel    = 3'h0;
  logic [3:0]         acceptDelay = 4'h0;
  logic               awReady, wReady, bValid, arReady, rValid;
  logic [1:0]         bResp, rResp;
  logic [DATA_W-1:0]  rData;
  logic               coreAccept, irqReq;
  logic [LVL_W-1:0]   irqLevel;
  logic [VEC_W-1:0]   irqVector;
  logic [LVL_W-1:0]   lv [NUM_SRC];
  int                 miscompares = 0;
  int                 nCompared   = 0;

  // 200 MHz system clock
  always #2.5 sys_clk = ~sys_clk;

  ilpc_top dut_u (
    .sys_clk       (sys_clk),
    .srst          (srst),
    .s_axi_awaddr  (awAddr),
    .s_axi_awvalid (awValid),
    .s_axi_awready (awReady),
    .s_axi_wdata   (wData),
    .s_axi_wstrb   (wStrb),
    .s_axi_wvalid  (wValid),
    .s_axi_wready  (wReady),
    .s_axi_bresp   (bResp),
    .s_axi_bvalid  (bValid),
    .s_axi_bready  (bReady),
    .s_axi_araddr  (arAddr),
    .s_axi_arvalid (arValid),
    .s_axi_arready (arReady),
    .s_axi_rdata   (rData),
    .s_axi_rresp   (rResp),
    .s_axi_rvalid  (rValid),
    .s_axi_rready  (rReady),
    .srcReq        (srcReq),
    .coreAccept    (coreAccept),
    .irqReq        (irqReq),
    .irqLevel      (irqLevel),
    .irqVector     (irqVector)
  );

  ilpc_core_model core_u (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .irqReq      (irqReq),
    .irqLevel    (irqLevel),
    .acceptEn    (acceptEn),
    .curLevel    (curLevel),
    .acceptDelay (acceptDelay),
    .coreAccept  (coreAccept)
  );

  // Count and report a mismatch
  task automatic fail(input string m);
    miscompares++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic chk32(input logic [31:0] got, exp, input string m);
    nCompared++;
    if (got !== exp) fail(m);
  endtask

  // Best pending source: highest level, lowest index on ties
  function automatic int bestIdx(input logic [NUM_SRC-1:0] m);
    int b;
    b = -1;
    for (int s = 0; s < NUM_SRC; s++)
      if (m[s] && lv[s] != 3'h0 && (b < 0 || lv[s] > lv[b])) b = s;
    return b;
  endfunction

  // Compare the core link outputs with the expected winner
  task automatic chkIrq(input logic [NUM_SRC-1:0] m);
    int b;
    b = bestIdx(m);
    nCompared++;
    if (b < 0) begin
      if (irqReq !== 1'b0) fail("request while nothing eligible");
    end else if (irqReq !== 1'b1 || irqLevel !== lv[b] ||
                 irqVector !== VEC_BASE + 5'(b)) begin
      fail("wrong request presented");
    end
  endtask

  function automatic logic [15:0] regWord(input int k);
    return {5'h0, lv[2*k+1], 5'h0, lv[2*k]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Write one register, both channels offered together
  task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [15:0] d,
                          input logic [1:0] er);
    int n;
    bit aw, w;
    n = 0;
    aw = 0;
    w = 0;
    @(posedge sys_clk);
    awAddr  <= a;
    awValid <= 1'b1;
    wData   <= {16'h0, d};
    wStrb   <= 4'h3;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    while (!(aw && w) && n < 100) begin
      @(posedge sys_clk);
      n++;
      if (!aw && awReady === 1'b1) begin
        aw = 1;
        awValid <= 1'b0;
      end
      if (!w && wReady === 1'b1) begin
        w = 1;
        wValid <= 1'b0;
      end
    end
    do begin
      @(posedge sys_clk);
      n++;
    end while (bValid !== 1'b1 && n < 200);
    bReady <= 1'b0;
    if (bValid !== 1'b1) fail("write not answered");
    chk32({30'h0, bResp}, {30'h0, er}, "write response");
  endtask

  // Read one register and compare data and response
  task automatic axiRead(input logic [ADDR_W-1:0] a, input logic [15:0] ed,
                         input logic [1:0] er);
    int n;
    n = 0;
    @(posedge sys_clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arReady === 1'b1) arValid <= 1'b0;
    end while (rValid !== 1'b1 && n < 200);
    rReady <= 1'b0;
    if (rValid !== 1'b1) fail("read not answered");
    chk32({30'h0, rResp}, {30'h0, er}, "read response");
    chk32(rData, {16'h0, ed}, "read data");
  endtask

  task automatic waitAccept;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(coreAccept === 1'b1 && irqReq === 1'b1) && n < 100);
    if (n >= 100) fail("no request taken");
  endtask

  // Core takes each request; software then clears its flag
  task automatic serve(input logic [NUM_SRC-1:0] m);
    int b;
    b = bestIdx(m);
    while (b >= 0) begin
      waitAccept();
      chkIrq(m);
      srcReq <= srcReq & ~(20'h1 << b); // Flag cleared
      m[b] = 1'b0;
      b = bestIdx(m);
    end
  endtask

  task automatic stopTest;
    $display("compared %0d mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    for (int s = 0; s < NUM_SRC; s++) lv[s] = 3'h0;
    tick(5);
    srst <= 1'b0;
    for (int k = 0; k < NUM_REG; k++)
      axiRead({REG_IDX[k], 2'b00}, 16'h0, RESP_OKAY); // Reset
    // Distinct levels, ties at 7, zeros; source 17 has no field
    for (int s = 0; s < NUM_SRC; s++)
      lv[s] = (s == 17) ? 3'h0 : 3'((s * 3 + 1) % 8);
    for (int k = 0; k < NUM_REG; k++)
      axiWrite({REG_IDX[k], 2'b00}, regWord(k), RESP_OKAY);
    for (int k = 0; k < NUM_REG; k++)
      axiRead({REG_IDX[k],2'b00},regWord(k),RESP_OKAY);
    axiWrite(18'h10c68, 16'h0007, RESP_SLVERR); // Unmapped
    axiRead(18'h10c68, 16'h0, RESP_SLVERR); // Unmapped
    srcReq <= 20'h40425;
    tick(3);
    chkIrq(20'h40425); // Winner
    acceptEn <= 1'b1;
    serve(20'h40425); // Losers in falling order
    tick(4);
    chkIrq(20'h00020); // Level zero only
    acceptEn <= 1'b0;
    srcReq   <= 20'h1;
    tick(3);
    chkIrq(20'h1); // Single request
    srcReq <= 20'h81;
    tick(3);
    chkIrq(20'h81); // Newcomer displaces
    acceptDelay <= 4'h3;
    acceptEn    <= 1'b1;
    serve(20'h81); // Displaced one kept
    tick(1);
    acceptEn <= 1'b0;
    srcReq   <= 20'h8;
    tick(3);
    chkIrq(20'h8); // Held request
    srcReq <= 20'h0;
    tick(3);
    chkIrq(20'h0); // Cleared flag dropped
    acceptDelay <= 4'h0;
    acceptEn    <= 1'b1;
    srcReq      <= 20'h2;
    waitAccept();
    waitAccept();
    chkIrq(20'h2); // Flag still set re-raises
    srcReq   <= 20'h0;
    acceptEn <= 1'b0;
    tick(1);
    srcReq <= 20'h50;
    tick(3);
    chkIrq(20'h50); // Before level change
    lv[4] = 3'h1;
    axiWrite({REG_IDX[2], 2'b00}, regWord(2), RESP_OKAY);
    tick(3);
    chkIrq(20'h50); // New level used
    curLevel <= 3'h4;
    acceptEn <= 1'b1;
    srcReq   <= 20'hd0;
    serve(20'h80); // Only level above current taken
    tick(6);
    chkIrq(20'h50); // Refused ones stay pending
    srcReq <= 20'h0;
    tick(2);
    stopTest();
  end

  // Watchdog against a hang
  initial begin
    tick(20000);
    fail("watchdog expired");
    stopTest();
  end
endmodule
`default_nettype wire
